// ### isio_pkg.sv
// constants and types of the isa slave i/o and interrupt block
//==================================================================
package isio_pkg;

	//==================================================================
	// register map, byte addresses on the register port
	localparam logic [7:0] ISIO_OFS_STATUS   = 8'hE0;
	localparam logic [7:0] ISIO_OFS_MASK     = 8'hE4;
	localparam logic [7:0] ISIO_OFS_IOBASE   = 8'hE8;
	localparam logic [7:0] ISIO_OFS_IRQSEL   = 8'hEC;
	localparam logic [7:0] ISIO_OFS_IO_WIDTH = 8'hF0;

	//==================================================================
	// field layout and reset values
	localparam int         ISIO_NFLAGS       = 6;
	localparam int         ISIO_WIDE_BIT     = 0;
	localparam int         ISIO_BASE_W       = 6;
	localparam int         ISIO_SEL_W        = 3;
	localparam logic [5:0] ISIO_MASK_RST     = 6'h3F;
	localparam logic [5:0] ISIO_BASE_RST     = 6'h30;
	localparam logic [2:0] ISIO_SEL_RST      = 3'h0;
	localparam logic [7:0] ISIO_WIDTH_RST    = 8'h00;

	// status bit positions
	localparam int ISIO_B_BABBLE  = 0;
	localparam int ISIO_B_MISSED  = 1;
	localparam int ISIO_B_MEMERR  = 2;
	localparam int ISIO_B_RECEIVE = 3;
	localparam int ISIO_B_INIT    = 4;
	localparam int ISIO_B_TXSTART = 5;

	//==================================================================
	// slave access sequencer states
	typedef enum logic [1:0] {
		ISIO_ST_IDLE = 2'b00,
		ISIO_ST_WAIT = 2'b01,
		ISIO_ST_DONE = 2'b10
	} isio_state_t;

	// one slave access handed to the device core
	typedef struct packed {
		logic        wr;
		logic        wide;
		logic [3:0]  offset;
		logic [15:0] data;
	} isio_req_t;

endpackage

// ### isio_irq.sv
// sticky interrupt status, mask and interrupt level
`timescale 1ns/100ps
module isio_irq #(
	parameter int N = 6
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [N-1:0] set_ev,
	input  wire logic         clr_wr,
	input  wire logic [N-1:0] clr_data,
	input  wire logic         mask_wr,
	input  wire logic [N-1:0] mask_data,
	output logic      [N-1:0] status,
	output logic      [N-1:0] mask,
	output logic              irq
);

	//==================================================================
	// next values: a set in the clear cycle wins, so no event is lost
	wire [N-1:0] next_status = (status & ~({N{clr_wr}} & clr_data)) | set_ev;
	wire         next_irq    = |(next_status & ~mask);

	//==================================================================
	// status and mask flops
	always_ff @(posedge clk) begin
		if (!resetn) begin
			status <= '0;
			mask   <= N'(isio_pkg::ISIO_MASK_RST);
		end else begin
			status <= next_status;
			if (mask_wr) begin
				mask <= mask_data;
			end
		end
	end

	// level output, the or of unmasked flags
	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

endmodule

// ### isio_slave.sv
// isa slave i/o access sequencer, width decode and interrupt line drive
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
module isio_slave #(
	parameter int IRQ_LINES = 8
) (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic [15:0]           sa,
	input  wire logic                  aen,
	input  wire logic                  ior_n,
	input  wire logic                  iow_n,
	input  wire logic                  memr_n,
	input  wire logic                  sbhe_n,
	input  wire logic [15:0]           sd_in,
	output logic      [15:0]           sd_out,
	output logic                       sd_oe,
	output logic                       iochrdy_out,
	output logic                       iochrdy_oe,
	output logic                       iocs16_n_out,
	output logic                       iocs16_n_oe,
	output logic      [IRQ_LINES-1:0]  irq_out,
	output logic      [IRQ_LINES-1:0]  irq_oe,
	output logic                       mem_read_seen,
	output isio_pkg::isio_req_t        core_req,
	output logic                       core_req_valid,
	input  wire logic                  core_ack,
	input  wire logic [15:0]           core_rdata,
	input  wire logic [5:0]            flag_ev,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata
);

	//==================================================================
	// elaboration check: the select field reaches at most 8 lines
	generate
		if (IRQ_LINES < 2 || IRQ_LINES > 8) begin : g_bad_lines
			$error("IRQ_LINES must lie between 2 and 8");
		end
	endgenerate

	//==================================================================
	// address match, used by the width decode and the qualifier
	function automatic logic isio_match(
		input logic [15:0] a,
		input logic [5:0]  base,
		input logic        en
	);
		isio_match = !en && (a[9:4] == base);
	endfunction

	//==================================================================
	// registers
	isio_pkg::isio_state_t state;
	isio_pkg::isio_state_t next_state;
	logic [5:0]            io_base;
	logic [2:0]            irq_sel;
	logic [7:0]            io_width_config;
	logic                  sbhe_q;
	logic                  sbhe_seen;
	logic                  memr_q;
	logic                  cur_wr;
	logic [5:0]            status;
	logic [5:0]            mask;
	logic                  irq_level;

	//==================================================================
	// register port decode
	wire hit_status = reg_addr == isio_pkg::ISIO_OFS_STATUS;
	wire hit_mask   = reg_addr == isio_pkg::ISIO_OFS_MASK;
	wire hit_base   = reg_addr == isio_pkg::ISIO_OFS_IOBASE;
	wire hit_sel    = reg_addr == isio_pkg::ISIO_OFS_IRQSEL;
	wire hit_width  = reg_addr == isio_pkg::ISIO_OFS_IO_WIDTH;

	wire [7:0] rd_mux =
		hit_status ? {2'h0, status} :
		hit_mask   ? {2'h0, mask} :
		hit_base   ? {2'h0, io_base} :
		hit_sel    ? {5'h00, irq_sel} :
		hit_width  ? io_width_config : 8'h00;

	//==================================================================
	// isa side decode
	wire addr_hit  = isio_match(sa, io_base, aen);
	wire wide_ok   = io_width_config[isio_pkg::ISIO_WIDE_BIT];
	// strobe-free decode keeps the chip select early enough for the host
	wire cs16_next = addr_hit && wide_ok && sbhe_seen;
	wire qual_rd   = addr_hit && !ior_n;
	wire qual_wr   = addr_hit && !iow_n;
	wire start     = (state == isio_pkg::ISIO_ST_IDLE) && (qual_rd || qual_wr);
	wire strobes_off = ior_n && iow_n;
	// a wide transfer needs the chip select and the high byte enabled
	wire wide_xfer = iocs16_n_oe && !sbhe_n;

	//==================================================================
	// interrupt status unit
	isio_irq #(
		.N (isio_pkg::ISIO_NFLAGS)
	) u_irq (
		.clk       (clk),
		.resetn    (resetn),
		.set_ev    (flag_ev),
		.clr_wr    (reg_wr && hit_status),
		.clr_data  (reg_wdata[5:0]),
		.mask_wr   (reg_wr && hit_mask),
		.mask_data (reg_wdata[5:0]),
		.status    (status),
		.mask      (mask),
		.irq       (irq_level)
	);

	//==================================================================
	// configuration registers written by software
	always_ff @(posedge clk) begin
		if (!resetn) begin
			io_base         <= isio_pkg::ISIO_BASE_RST;
			irq_sel         <= isio_pkg::ISIO_SEL_RST;
			io_width_config <= isio_pkg::ISIO_WIDTH_RST;
		end else if (reg_wr) begin
			if (hit_base) begin
				io_base <= reg_wdata[5:0];
			end
			if (hit_sel) begin
				irq_sel <= reg_wdata[2:0];
			end
			if (hit_width) begin
				io_width_config <= reg_wdata;
			end
		end
	end

	// read data stand for exactly the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
		end
	end

	//==================================================================
	// byte high enable history; a byte-only host never drops it
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sbhe_q    <= 1'b1;
			sbhe_seen <= 1'b0;
		end else begin
			sbhe_q <= sbhe_n;
			if (sbhe_q && !sbhe_n) begin
				sbhe_seen <= 1'b1;
			end
		end
	end

	// memory read start, one pulse per falling strobe
	always_ff @(posedge clk) begin
		if (!resetn) begin
			memr_q        <= 1'b1;
			mem_read_seen <= 1'b0;
		end else begin
			memr_q        <= memr_n;
			mem_read_seen <= memr_q && !memr_n;
		end
	end

	//==================================================================
	// 16-bit chip select, open drain: low level, enable while pulled
	always_ff @(posedge clk) begin
		if (!resetn) begin
			iocs16_n_out <= 1'b0;
			iocs16_n_oe  <= 1'b0;
		end else begin
			iocs16_n_out <= 1'b0;
			iocs16_n_oe  <= cs16_next;
		end
	end

	//==================================================================
	// access sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			isio_pkg::ISIO_ST_IDLE: begin
				if (start) begin
					next_state = isio_pkg::ISIO_ST_WAIT;
				end
			end
			isio_pkg::ISIO_ST_WAIT: begin
				if (core_ack) begin
					next_state = isio_pkg::ISIO_ST_DONE;
				end
			end
			isio_pkg::ISIO_ST_DONE: begin
				if (strobes_off) begin
					next_state = isio_pkg::ISIO_ST_IDLE;
				end
			end
			default: begin
				next_state = isio_pkg::ISIO_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= isio_pkg::ISIO_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	//==================================================================
	// request to the core, write data captured at the start
	always_ff @(posedge clk) begin
		if (!resetn) begin
			core_req       <= '0;
			core_req_valid <= 1'b0;
			cur_wr         <= 1'b0;
		end else begin
			core_req_valid <= start;
			if (start) begin
				cur_wr          <= qual_wr;
				core_req.wr     <= qual_wr;
				core_req.wide   <= wide_xfer;
				core_req.offset <= sa[3:0];
				core_req.data   <= sd_in;
			end
		end
	end

	//==================================================================
	// ready held low while the core works, data bus driven on reads
	always_ff @(posedge clk) begin
		if (!resetn) begin
			iochrdy_out <= 1'b0;
			iochrdy_oe  <= 1'b0;
			sd_out      <= 16'h0000;
			sd_oe       <= 1'b0;
		end else begin
			iochrdy_out <= 1'b0;
			if (start) begin
				iochrdy_oe <= 1'b1;
			end else if (state == isio_pkg::ISIO_ST_WAIT && core_ack) begin
				iochrdy_oe <= 1'b0;
			end
			if (state == isio_pkg::ISIO_ST_WAIT && core_ack && !cur_wr) begin
				sd_out <= core_rdata;
				sd_oe  <= 1'b1;
			end else if (state == isio_pkg::ISIO_ST_DONE && strobes_off) begin
				sd_oe <= 1'b0;
			end
		end
	end

	//==================================================================
	// interrupt line: only the selected line is driven
	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_out <= '0;
			irq_oe  <= '0;
		end else begin
			for (int i = 0; i < IRQ_LINES; i++) begin
				irq_oe[i]  <= (irq_sel == 3'(i));
				irq_out[i] <= (irq_sel == 3'(i)) && irq_level;
			end
		end
	end

	//==================================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	wire irq_now  = |(irq_out & irq_oe);
	wire unmasked = |(status & ~mask);

	sequence s_ack_in_wait;
		state == isio_pkg::ISIO_ST_WAIT && core_ack;
	endsequence

	sequence s_quiet_flags;
		!unmasked [*2];
	endsequence

	rdy_hold_a: assert property (
		state == isio_pkg::ISIO_ST_WAIT |-> iochrdy_oe)
		else $error("ready released while the core works");

	rdy_release_a: assert property (
		s_ack_in_wait |=> !iochrdy_oe && (cur_wr || sd_oe))
		else $error("ready not released with valid data");

	cs16_decode_a: assert property (
		iocs16_n_oe == $past(addr_hit && wide_ok && sbhe_seen))
		else $error("chip select differs from address decode");

	cs16_narrow_a: assert property (
		!wide_ok ##1 !wide_ok |-> !iocs16_n_oe)
		else $error("chip select driven in byte-only mode");

	byte_only_a: assert property (
		!sbhe_seen |=> !iocs16_n_oe)
		else $error("wide access offered before high enable fell");

	read_qual_a: assert property (
		state == isio_pkg::ISIO_ST_IDLE && (aen || !addr_hit) |=> !core_req_valid)
		else $error("access started without qualification");

	write_take_a: assert property (
		start && qual_wr |=> core_req_valid && core_req.wr && iochrdy_oe)
		else $error("qualified write not taken");

	drive_read_a: assert property (
		sd_oe |-> state != isio_pkg::ISIO_ST_IDLE && !cur_wr)
		else $error("data bus driven outside a read");

	irq_masked_a: assert property (
		s_quiet_flags |=> !irq_now)
		else $error("interrupt raised by masked flags");

	irq_raise_a: assert property (
		unmasked |-> ##[1:2] irq_now)
		else $error("unmasked flag did not raise interrupt");

endmodule

// ### isio_host_model.sv
// isa host bus model that drives address, strobes and data toward the slave
`timescale 1ns/100ps
module isio_host_model (
	input  wire logic        clk,
	input  wire logic [15:0] sd_out,
	input  wire logic        sd_oe,
	input  wire logic        iochrdy_out,
	input  wire logic        iochrdy_oe,
	input  wire logic        iocs16_n_out,
	input  wire logic        iocs16_n_oe,
	output logic      [15:0] sa,
	output logic             aen,
	output logic             ior_n,
	output logic             iow_n,
	output logic             memr_n,
	output logic             sbhe_n,
	output logic      [15:0] sd_in
);
	//==================================================================
	// wire levels: ready and chip select have pull-ups when not pulled low
	wire logic rdy_w  = iochrdy_oe ? iochrdy_out : 1'b1;
	wire logic cs16_w = iocs16_n_oe ? iocs16_n_out : 1'b1;

	// bus idle: no strobes, address enable high as during dma
	initial begin
		sa = 16'h0000;
		aen = 1'b1;
		ior_n = 1'b1;
		iow_n = 1'b1;
		memr_n = 1'b1;
		sbhe_n = 1'b1;
		sd_in = 16'h5A3C;
	end

	//==================================================================
	// one i/o cycle; a read of an undriven bus sees a changed pattern
	task automatic io_cycle(input logic wr, input logic aen_v, input logic [15:0] a,
		input logic [15:0] wd, output logic [15:0] rd, output logic cs, output int waits);
		sa <= a;
		aen <= aen_v;
		sd_in <= wr ? wd : ~sd_in;
		// address leads the strobe by a clock, as on the real bus, so that the
		// registered chip select already stands when the access starts
		@(posedge clk);
		ior_n <= wr;
		iow_n <= ~wr;
		// a cycle is never shorter than two clocks, ready is looked at from then on
		repeat (2) @(posedge clk);
		waits = 0;
		while (rdy_w !== 1'b1 && waits < 64) begin
			waits++;
			@(posedge clk);
		end
		rd = sd_oe ? sd_out : ~sd_out;
		cs = cs16_w;
		ior_n <= 1'b1;
		iow_n <= 1'b1;
		aen <= 1'b1;
		sd_in <= ~sd_in;
		repeat (2) @(posedge clk);
	endtask

	// address and high enable alone, no strobe, then the chip select level
	task automatic addr_hold(input logic [15:0] a, input logic aen_v, input logic hi_n,
		output logic cs);
		sa <= a;
		aen <= aen_v;
		sbhe_n <= hi_n;
		repeat (3) @(posedge clk);
		cs = cs16_w;
	endtask

	// memory read cycle
	task automatic mem_read();
		memr_n <= 1'b0;
		repeat (2) @(posedge clk);
		memr_n <= 1'b1;
		@(posedge clk);
	endtask
endmodule

// ### isio_slave_tb_top.sv
// self-checking bench for the isa slave i/o and interrupt block
`timescale 1ns/100ps
module isio_slave_tb_top;
	logic                clk = 1'b0;
	logic                resetn = 1'b0;
	logic [15:0]         sa, sd_in, sd_out, rd;
	logic                aen, ior_n, iow_n, memr_n, sbhe_n, sd_oe, cs;
	logic                iochrdy_out, iochrdy_oe, iocs16_n_out, iocs16_n_oe;
	logic [7:0]          irq_out, irq_oe, reg_rdata, rv;
	logic                mem_read_seen, core_req_valid;
	isio_pkg::isio_req_t core_req, last_req;
	logic                core_ack = 1'b0;
	logic [15:0]         core_rdata = 16'h0000;
	logic [5:0]          flag_ev = 6'h00;
	logic [7:0]          reg_addr = 8'h00;
	logic [7:0]          reg_wdata = 8'h00;
	logic                reg_wr = 1'b0;
	logic                reg_rd = 1'b0;
	int                  fail_count = 0, checks_done = 0, waits, cyc = 0;
	int                  req_n = 0, mem_n = 0, ack_delay = 1, ack_cnt = 0;
	logic [7:0]          addrs[6] = '{8'hE0, 8'hE4, 8'hE8, 8'hEC, 8'hF0, 8'h10};
	logic [7:0]          rstv[6]  = '{8'h00, 8'h3F, 8'h30, 8'h00, 8'h00, 8'h00};

	always #5 clk = ~clk;

	isio_slave #(.IRQ_LINES(8)) isio_slave_inst (.clk, .resetn, .sa, .aen, .ior_n, .iow_n,
		.memr_n, .sbhe_n, .sd_in, .sd_out, .sd_oe, .iochrdy_out, .iochrdy_oe, .iocs16_n_out,
		.iocs16_n_oe, .irq_out, .irq_oe, .mem_read_seen, .core_req, .core_req_valid,
		.core_ack, .core_rdata, .flag_ev, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	isio_host_model isio_host_model_inst (.clk, .sd_out, .sd_oe, .iochrdy_out, .iochrdy_oe,
		.iocs16_n_out, .iocs16_n_oe, .sa, .aen, .ior_n, .iow_n, .memr_n, .sbhe_n, .sd_in);

	//==================================================================
	// device core stand-in: answers each request after ack_delay cycles
	always @(posedge clk) begin
		core_ack <= 1'b0;
		if (core_req_valid === 1'b1) begin
			req_n <= req_n + 1;
			last_req <= core_req;
			ack_cnt <= ack_delay;
		end else if (ack_cnt > 0) begin
			ack_cnt <= ack_cnt - 1;
			core_ack <= (ack_cnt == 1);
		end
		if (mem_read_seen === 1'b1) begin
			mem_n <= mem_n + 1;
		end
		// a hang is cut short well past the expected run length
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			summarize();
		end
	end

	//==================================================================
	// tasks: compare, register port, verdict
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask

	// data stand in the cycle after the strobe, seen here at the edge ending it
	task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		rv = reg_rdata;
		chk("register read", 32'(exp), 32'(rv));
	endtask

	task automatic summarize();
		if (fail_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	//==================================================================
	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		// reset values, then an unmapped address that ignores writes
		for (int i = 0; i < 6; i++) begin
			reg_chk(addrs[i], rstv[i]);
		end
		reg_write(8'h10, 8'hFF);
		reg_chk(8'h10, 8'h00);
		reg_write(8'hF0, 8'h01);
		reg_chk(8'hF0, 8'h01);
		reg_write(8'hF0, 8'h00);
		// byte-only write; a word is split into two byte cycles
		isio_host_model_inst.io_cycle(1'b1, 1'b0, 16'h0306, 16'h0034, rd, cs, waits);
		chk("write request", 32'({1'b1, 1'b0, 4'h6, 16'h0034}), 32'(last_req));
		chk("byte only cs16", 32'h1, 32'(cs));
		isio_host_model_inst.io_cycle(1'b1, 1'b0, 16'h0307, 16'h0012, rd, cs, waits);
		chk("write data", 32'({1'b1, 1'b0, 4'h7, 16'h0012}), 32'(last_req));
		chk("request count", 32'd2, 32'(req_n));
		// slow core: ready stays low until data are on the bus
		ack_delay = 6;
		core_rdata <= 16'hBEEF;
		isio_host_model_inst.io_cycle(1'b0, 1'b0, 16'h030A, 16'h0000, rd, cs, waits);
		chk("read data", 32'h0000BEEF, 32'(rd));
		chk("read request", 32'h0A, 32'(last_req[21:16]));
		chk("wait states", 32'h1, 32'(waits >= 6));
		chk("ready after data", 32'h0, 32'(waits > 12));
		ack_delay = 1;
		// address enable high, then an address outside the block: both ignored
		isio_host_model_inst.io_cycle(1'b0, 1'b1, 16'h0305, 16'h0000, rd, cs, waits);
		isio_host_model_inst.io_cycle(1'b1, 1'b0, 16'h0310, 16'hFFFF, rd, cs, waits);
		chk("refused count", 32'd3, 32'(req_n));
		chk("refused wait", 32'd0, 32'(waits));
		// moved base: the new block answers, the old one is refused
		reg_write(8'hE8, 8'h31);
		isio_host_model_inst.io_cycle(1'b1, 1'b0, 16'h0315, 16'h00AB, rd, cs, waits);
		chk("moved base", 32'({1'b1, 1'b0, 4'h5, 16'h00AB}), 32'(last_req));
		isio_host_model_inst.io_cycle(1'b0, 1'b0, 16'h0305, 16'h0000, rd, cs, waits);
		chk("old base refused", 32'd4, 32'(req_n));
		reg_write(8'hE8, 8'h30);
		// chip select: needs a high enable fall, decodes address, enable and width bit only
		reg_write(8'hF0, 8'h01);
		isio_host_model_inst.addr_hold(16'h0300, 1'b0, 1'b1, cs);
		chk("cs16 before fall", 32'h1, 32'(cs));
		isio_host_model_inst.addr_hold(16'h0300, 1'b0, 1'b0, cs);
		chk("cs16 no strobe", 32'h0, 32'(cs));
		isio_host_model_inst.addr_hold(16'h0300, 1'b1, 1'b0, cs);
		chk("cs16 with aen", 32'h1, 32'(cs));
		isio_host_model_inst.io_cycle(1'b0, 1'b0, 16'h0302, 16'h0000, rd, cs, waits);
		chk("cs16 in cycle", 32'h0, 32'(cs));
		chk("wide request", 32'h1, 32'(last_req.wide));
		reg_write(8'hF0, 8'h00);
		isio_host_model_inst.addr_hold(16'h0300, 1'b0, 1'b0, cs);
		chk("cs16 byte only", 32'h1, 32'(cs));
		// interrupts on line 3: masked, unmasked, cleared, for every flag
		reg_write(8'hEC, 8'h03);
		@(posedge clk);
		chk("irq drive", 32'h08, 32'(irq_oe));
		for (int i = 0; i < 6; i++) begin
			reg_write(8'hE4, 8'h3F);
			flag_ev <= 6'(1 << i);
			@(posedge clk);
			flag_ev <= 6'h00;
			repeat (3) @(posedge clk);
			chk("masked irq", 32'h00, 32'(irq_out));
			reg_chk(8'hE0, 8'(1 << i));
			reg_write(8'hE4, 8'h00);
			repeat (2) @(posedge clk);
			chk("irq line", 32'h08, 32'(irq_out));
			reg_write(8'hE0, 8'(1 << i));
			repeat (2) @(posedge clk);
			chk("irq cleared", 32'h00, 32'(irq_out));
		end
		isio_host_model_inst.mem_read();
		chk("memory read seen", 32'd1, 32'(mem_n));
		summarize();
	end
endmodule
